// ### verilog/ocr_pkg.sv
// constants, field layout and state codes of the overcurrent fault and warning block

package ocr_pkg;

   localparam int OCR_NUM_PHASES = 2;
   localparam int OCR_PHASE_IDX_W = 1;

   // command codes of the two settings and the all-phase select code
   localparam logic [7:0] OCR_CMD_FAULT_ACTION = 8'h47;
   localparam logic [7:0] OCR_CMD_WARN_THRESHOLD = 8'h4A;
   localparam logic [7:0] OCR_PHASE_ALL = 8'hFF;

   // fault action byte fields
   localparam int OCR_REACT_MSB = 7;
   localparam int OCR_REACT_LSB = 6;
   localparam int OCR_RETRY_MSB = 5;
   localparam int OCR_RETRY_LSB = 3;
   localparam int OCR_DELAY_MSB = 2;
   localparam int OCR_DELAY_LSB = 0;
   localparam logic [7:0] OCR_FAULT_ACTION_RST = 8'h80;
   localparam logic [1:0] OCR_REACT_DELAYED = 2'h2;
   localparam logic [1:0] OCR_REACT_IMMEDIATE = 2'h3;
   localparam logic [2:0] OCR_RETRY_LATCH = 3'h0;
   localparam logic [2:0] OCR_RETRY_FOREVER = 3'h7;
   localparam logic [2:0] OCR_DELAY_SEL_MID = 3'h2;
   localparam logic [2:0] OCR_DELAY_SEL_HIGH = 3'h5;
   localparam logic [2:0] OCR_SHUT_TICKS_SHORT = 3'h1;
   localparam logic [2:0] OCR_SHUT_TICKS_MID = 3'h3;
   localparam logic [2:0] OCR_SHUT_TICKS_LONG = 3'h7;

   // warning threshold word fields, linear format
   localparam int OCR_EXP_MSB = 15;
   localparam int OCR_EXP_LSB = 11;
   localparam int OCR_MAN_MSB = 10;
   localparam logic [4:0] OCR_WARN_EXP_RST = 5'h1E;
   localparam logic [10:0] OCR_WARN_MAN_RST = 11'h0A0;
   localparam logic [15:0] OCR_WARN_WORD_RST = {OCR_WARN_EXP_RST, OCR_WARN_MAN_RST};
   localparam logic [4:0] OCR_EXP_WR_MIN = 5'h1C;
   localparam logic [4:0] OCR_EXP_WR_MAX = 5'h1E;
   localparam logic [4:0] OCR_EXP_STORED_MIN = 5'h1B;
   localparam logic [4:0] OCR_EXP_ONE = 5'h01;
   // limits in 1/32 A units
   localparam logic [12:0] OCR_LIMIT_PHASE_32 = 13'h07C0;
   localparam logic [12:0] OCR_LIMIT_ALL_32 = 13'h0F80;
   // hardware step grid: 2 A steps, 8 A to 62 A
   localparam logic [13:0] OCR_STEP_ROUND_UP = 14'h003F;
   localparam int OCR_STEP_SHIFT = 6;
   localparam logic [7:0] OCR_STEPS_MIN = 8'h04;
   localparam logic [7:0] OCR_STEPS_MAX = 8'h1F;
   localparam logic [5:0] OCR_HW_AMPS_MIN = 6'h08;
   localparam logic [5:0] OCR_HW_AMPS_MAX = 6'h3E;
   // stored grid: quarter amps up to 62 A
   localparam logic [13:0] OCR_QUARTER_ROUND = 14'h0004;
   localparam int OCR_QUARTER_SHIFT = 3;
   localparam logic [10:0] OCR_QUARTERS_MAX = 11'h0F8;

   // timing
   localparam int OCR_CLK_PERIOD_NS = 10;
   localparam int OCR_PWM_FREQ_KHZ = 500;
   localparam int OCR_PWM_PERIOD_NS = 1000000 / OCR_PWM_FREQ_KHZ;
   localparam int OCR_PWM_DIV_CYCLES = OCR_PWM_PERIOD_NS / OCR_CLK_PERIOD_NS;
   localparam logic [7:0] OCR_PWM_DIV_LAST = 8'(OCR_PWM_DIV_CYCLES - 1);
   localparam int OCR_US_NS = 1000;
   localparam int OCR_US_CYCLES = OCR_US_NS / OCR_CLK_PERIOD_NS;
   localparam logic [6:0] OCR_US_DIV_LAST = 7'(OCR_US_CYCLES - 1);

   // fault response states
   typedef enum logic [5:0] {
      OCR_ST_OFF = 6'b000001,
      OCR_ST_START = 6'b000010,
      OCR_ST_RUN = 6'b000100,
      OCR_ST_DELAY = 6'b001000,
      OCR_ST_WAIT = 6'b010000,
      OCR_ST_LATCH = 6'b100000
   } ocr_state_e;

endpackage

// ### verilog/ocr_limit_quantizer.sv
// maps one per-phase warning limit word onto the hardware step and the stored grid
`timescale 1ns/100ps
`default_nettype none

module ocr_limit_quantizer
   import ocr_pkg::*;
(
   input wire logic [15:0] limit_word,
   output logic [5:0] hw_amps,
   output logic [15:0] nvm_word
);

   logic [1:0] shift_w;
   logic [12:0] units32_w;
   logic [7:0] steps_w;
   logic [10:0] quarters_w;

   // limit in 1/32 A; negative mantissa counts as zero
   assign shift_w = 2'(limit_word[OCR_EXP_MSB:OCR_EXP_LSB] - OCR_EXP_STORED_MIN);
   assign units32_w = limit_word[OCR_MAN_MSB] ? 13'h0000 :
      ({3'h0, limit_word[OCR_MAN_MSB-1:0]} << shift_w);

   // ceiling onto 2 A steps, then clamp into the 8 A to 62 A range
   assign steps_w = 8'(({1'b0, units32_w} + OCR_STEP_ROUND_UP) >> OCR_STEP_SHIFT);
   assign hw_amps = (steps_w < OCR_STEPS_MIN) ? OCR_HW_AMPS_MIN :
      (steps_w > OCR_STEPS_MAX) ? OCR_HW_AMPS_MAX : {steps_w[4:0], 1'b0};

   // nearest quarter amp, capped at 62 A, re-expressed at the reset exponent
   assign quarters_w = 11'(({1'b0, units32_w} + OCR_QUARTER_ROUND) >> OCR_QUARTER_SHIFT);
   assign nvm_word = {OCR_WARN_EXP_RST,
      (quarters_w > OCR_QUARTERS_MAX) ? OCR_QUARTERS_MAX : quarters_w};

endmodule

`default_nettype wire

// ### verilog/ocr_fault_warn.sv
// overcurrent fault response policy, restart control and per-phase warning logic
`timescale 1ns/100ps
`default_nettype none

module ocr_fault_warn
   import ocr_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic cmd_wr,
   input wire logic cmd_rd,
   input wire logic [7:0] cmd_code,
   input wire logic [15:0] cmd_wdata,
   input wire logic [7:0] phase_sel,
   output logic [15:0] cmd_rdata,
   output logic cmd_rd_valid,
   input wire logic output_on_cmd,
   input wire logic startup_done,
   input wire logic oc_fault_detect,
   input wire logic [15:0] rise_time_us,
   input wire logic [OCR_NUM_PHASES-1:0][11:0] phase_current,
   input wire logic clear_faults,
   input wire logic nvm_store,
   input wire logic nvm_restore,
   output logic power_stage_en,
   output logic [OCR_NUM_PHASES-1:0][5:0] warn_threshold_amps,
   output logic stat_byte_iout_oc,
   output logic stat_byte_none_above,
   output logic stat_word_iout,
   output logic stat_iout_fault,
   output logic [OCR_NUM_PHASES-1:0] stat_iout_warn,
   output logic stat_cml_invalid,
   output logic host_alert
);

   ocr_state_e state_reg, state_next;
   logic [7:0] fault_action_reg, fault_action_next, action_nvm_reg;
   logic [7:0] pwm_div_reg, pwm_div_next;
   logic [6:0] us_div_reg, us_div_next;
   logic [2:0] dly_cnt_reg, dly_cnt_next;
   logic [18:0] wait_cnt_reg, wait_cnt_next;
   logic [2:0] attempts_reg, attempts_next;
   logic pwm_tick, us_tick;
   logic [1:0] oc_reaction_select;
   logic [2:0] oc_restart_attempts, oc_shutdown_delay_select;
   logic [2:0] restart_wait_period_mult, shut_ticks;
   logic [18:0] restart_wait_period;
   logic shut_now, go_delay, dly_done, wait_done, retry_left;
   ocr_state_e shut_target;

   // pwm and microsecond enables from free-running dividers
   assign pwm_tick = (pwm_div_reg == OCR_PWM_DIV_LAST);
   assign pwm_div_next = pwm_tick ? 8'h00 : pwm_div_reg + 8'h01;
   assign us_tick = (us_div_reg == OCR_US_DIV_LAST);
   assign us_div_next = us_tick ? 7'h00 : us_div_reg + 7'h01;

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         pwm_div_reg <= 8'h00;
         us_div_reg <= 7'h00;
      end
      else
      begin
         pwm_div_reg <= pwm_div_next;
         us_div_reg <= us_div_next;
      end
   end

   // fault action fields
   assign oc_reaction_select = fault_action_reg[OCR_REACT_MSB:OCR_REACT_LSB];
   assign oc_restart_attempts = fault_action_reg[OCR_RETRY_MSB:OCR_RETRY_LSB];
   assign oc_shutdown_delay_select = fault_action_reg[OCR_DELAY_MSB:OCR_DELAY_LSB];

   // shutdown delay and restart_wait_period length from the delay field
   assign shut_ticks = (oc_shutdown_delay_select < OCR_DELAY_SEL_MID) ? OCR_SHUT_TICKS_SHORT :
      (oc_shutdown_delay_select < OCR_DELAY_SEL_HIGH) ? OCR_SHUT_TICKS_MID :
      OCR_SHUT_TICKS_LONG;
   assign restart_wait_period_mult = (oc_shutdown_delay_select < OCR_DELAY_SEL_MID) ? 3'h1 :
      oc_shutdown_delay_select;
   assign restart_wait_period = {3'h0, rise_time_us} * {16'h0000, restart_wait_period_mult};

   // fault policy decode
   assign shut_now = oc_fault_detect && (oc_reaction_select == OCR_REACT_IMMEDIATE);
   assign go_delay = oc_fault_detect && (oc_reaction_select == OCR_REACT_DELAYED);
   assign shut_target = (oc_restart_attempts == OCR_RETRY_LATCH) ? OCR_ST_LATCH : OCR_ST_WAIT;
   assign retry_left = (oc_restart_attempts == OCR_RETRY_FOREVER) ||
      (attempts_reg < oc_restart_attempts);
   assign dly_done = (dly_cnt_reg == shut_ticks);
   assign wait_done = (wait_cnt_reg >= restart_wait_period);
   assign power_stage_en = (state_reg == OCR_ST_START) || (state_reg == OCR_ST_RUN) ||
      (state_reg == OCR_ST_DELAY);

   // fault response state machine; commanding off wins over everything
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         OCR_ST_OFF:
            state_next = OCR_ST_START;
         OCR_ST_START:
            if (shut_now)
               state_next = shut_target;
            else if (go_delay)
               state_next = OCR_ST_DELAY;
            else if (startup_done)
               state_next = OCR_ST_RUN;
         OCR_ST_RUN:
            if (shut_now)
               state_next = shut_target;
            else if (go_delay)
               state_next = OCR_ST_DELAY;
         OCR_ST_DELAY:
            if (!oc_fault_detect)
               state_next = OCR_ST_RUN;
            else if (dly_done)
               state_next = shut_target;
         OCR_ST_WAIT:
            if (wait_done)
               state_next = retry_left ? OCR_ST_START : OCR_ST_LATCH;
         OCR_ST_LATCH:
            state_next = OCR_ST_LATCH;
         default:
            state_next = OCR_ST_OFF;
      endcase
      if (!output_on_cmd)
         state_next = OCR_ST_OFF;
   end

   // counters for the shutdown delay, the restart_wait_period wait and the restart budget
   assign dly_cnt_next = ((state_reg != OCR_ST_DELAY) || (state_next != OCR_ST_DELAY)) ? 3'h0 :
      (pwm_tick && !dly_done) ? dly_cnt_reg + 3'h1 : dly_cnt_reg;
   assign wait_cnt_next = (state_reg != OCR_ST_WAIT) ? 19'h00000 :
      (us_tick && !wait_done) ? wait_cnt_reg + 19'h00001 : wait_cnt_reg;
   assign attempts_next = ((state_next == OCR_ST_OFF) ||
      ((state_reg == OCR_ST_START) && (state_next == OCR_ST_RUN))) ? 3'h0 :
      ((state_reg == OCR_ST_WAIT) && (state_next == OCR_ST_START) &&
      (oc_restart_attempts != OCR_RETRY_FOREVER)) ? attempts_reg + 3'h1 : attempts_reg;

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         state_reg <= OCR_ST_OFF;
         dly_cnt_reg <= 3'h0;
         wait_cnt_reg <= 19'h00000;
         attempts_reg <= 3'h0;
      end
      else
      begin
         state_reg <= state_next;
         dly_cnt_reg <= dly_cnt_next;
         wait_cnt_reg <= wait_cnt_next;
         attempts_reg <= attempts_next;
      end
   end

   // command decode and warning threshold validation
   logic wr_action, wr_warn, phase_all, phase_ok, warn_ok;
   logic [4:0] wr_exp;
   logic [1:0] wr_shift;
   logic [12:0] wr_units32;
   logic [OCR_NUM_PHASES-1:0][15:0] warn_words;
   logic [OCR_NUM_PHASES-1:0] warn_hit;

   assign wr_action = cmd_wr && (cmd_code == OCR_CMD_FAULT_ACTION);
   assign wr_warn = cmd_wr && (cmd_code == OCR_CMD_WARN_THRESHOLD);
   assign phase_all = (phase_sel == OCR_PHASE_ALL);
   assign phase_ok = phase_all || (phase_sel < 8'(OCR_NUM_PHASES));
   assign wr_exp = cmd_wdata[OCR_EXP_MSB:OCR_EXP_LSB];
   assign wr_shift = 2'(wr_exp - OCR_EXP_STORED_MIN);
   assign wr_units32 = {3'h0, cmd_wdata[OCR_MAN_MSB-1:0]} << wr_shift;
   assign warn_ok = phase_ok && (wr_exp >= OCR_EXP_WR_MIN) && (wr_exp <= OCR_EXP_WR_MAX) &&
      !cmd_wdata[OCR_MAN_MSB] &&
      (wr_units32 <= (phase_all ? OCR_LIMIT_ALL_32 : OCR_LIMIT_PHASE_32));

   // fault action byte: every code is supported; store and restore keep a copy
   assign fault_action_next = nvm_restore ? action_nvm_reg :
      wr_action ? cmd_wdata[7:0] : fault_action_reg;

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         fault_action_reg <= OCR_FAULT_ACTION_RST;
         action_nvm_reg <= OCR_FAULT_ACTION_RST;
      end
      else
      begin
         fault_action_reg <= fault_action_next;
         if (nvm_store)
            action_nvm_reg <= fault_action_reg;
      end
   end

   // per-phase warning limit, its stored copy, hardware step and comparator
   genvar gi;
   generate
      for (gi = 0; gi < OCR_NUM_PHASES; gi++)
      begin : g_phase
         logic [15:0] word_reg, word_next, nvm_reg, rounded_w;
         logic [5:0] amps_w, amps_reg;
         logic wr_this;

         assign wr_this = wr_warn && warn_ok &&
            (phase_all || (phase_sel == 8'(gi)));
         // all-phase write halves the value by lowering the exponent
         assign word_next = nvm_restore ? nvm_reg : nvm_store ? rounded_w :
            !wr_this ? word_reg : phase_all ?
            {wr_exp - OCR_EXP_ONE, cmd_wdata[OCR_MAN_MSB:0]} : cmd_wdata;

         ocr_limit_quantizer u_quant (
            .limit_word(word_reg),
            .hw_amps(amps_w),
            .nvm_word(rounded_w)
         );

         always_ff @(posedge core_clk)
         begin
            if (rst)
            begin
               word_reg <= OCR_WARN_WORD_RST;
               nvm_reg <= OCR_WARN_WORD_RST;
               amps_reg <= OCR_HW_AMPS_MIN;
            end
            else
            begin
               word_reg <= word_next;
               amps_reg <= amps_w;
               if (nvm_store)
                  nvm_reg <= rounded_w;
            end
         end

         assign warn_words[gi] = word_reg;
         assign warn_threshold_amps[gi] = amps_reg;
         assign warn_hit[gi] = phase_current[gi] > {2'h0, amps_reg, 4'h0};
      end
   endgenerate

   // status flags: set wins over clear
   logic fault_event, invalid_event;
   logic byte_oc_next, none_above_next, word_iout_next, iout_fault_next, cml_next;
   logic [OCR_NUM_PHASES-1:0] iout_warn_next;

   assign fault_event = oc_fault_detect && power_stage_en;
   assign invalid_event = wr_warn && !warn_ok;
   assign byte_oc_next = fault_event || (stat_byte_iout_oc && !clear_faults);
   assign iout_fault_next = fault_event || (stat_iout_fault && !clear_faults);
   assign word_iout_next = fault_event || (|warn_hit) ||
      (stat_word_iout && !clear_faults);
   assign none_above_next = (|warn_hit) || (stat_byte_none_above && !clear_faults);
   assign iout_warn_next = warn_hit | (stat_iout_warn & {OCR_NUM_PHASES{!clear_faults}});
   assign cml_next = invalid_event || (stat_cml_invalid && !clear_faults);

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         stat_byte_iout_oc <= 1'b0;
         stat_byte_none_above <= 1'b0;
         stat_word_iout <= 1'b0;
         stat_iout_fault <= 1'b0;
         stat_iout_warn <= '0;
         stat_cml_invalid <= 1'b0;
         host_alert <= 1'b0;
      end
      else
      begin
         stat_byte_iout_oc <= byte_oc_next;
         stat_byte_none_above <= none_above_next;
         stat_word_iout <= word_iout_next;
         stat_iout_fault <= iout_fault_next;
         stat_iout_warn <= iout_warn_next;
         stat_cml_invalid <= cml_next;
         host_alert <= byte_oc_next || none_above_next || cml_next;
      end
   end

   // read path: all-phase read doubles phase zero by raising its exponent
   logic [15:0] rd_word;
   assign rd_word = (cmd_code == OCR_CMD_FAULT_ACTION) ? {8'h00, fault_action_reg} :
      (cmd_code != OCR_CMD_WARN_THRESHOLD) || !phase_ok ? 16'h0000 :
      phase_all ? {warn_words[0][OCR_EXP_MSB:OCR_EXP_LSB] + OCR_EXP_ONE,
      warn_words[0][OCR_MAN_MSB:0]} : warn_words[phase_sel[OCR_PHASE_IDX_W-1:0]];

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         cmd_rdata <= 16'h0000;
         cmd_rd_valid <= 1'b0;
      end
      else
      begin
         cmd_rd_valid <= cmd_rd;
         if (cmd_rd)
            cmd_rdata <= rd_word;
      end
   end

   // checks
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);

   property p_fault_status;
      fault_event |=> stat_iout_fault && stat_byte_iout_oc && stat_word_iout && host_alert;
   endproperty
   a_fault_status: assert property (p_fault_status) else $error("fault status not set");

   property p_immediate_off;
      (state_reg == OCR_ST_RUN) && shut_now && output_on_cmd |=> !power_stage_en;
   endproperty
   a_immediate_off: assert property (p_immediate_off) else $error("no immediate shutdown");

   property p_ignore;
      (state_reg == OCR_ST_RUN) && oc_fault_detect && !oc_reaction_select[1] && output_on_cmd
         |=> (state_reg == OCR_ST_RUN);
   endproperty
   a_ignore: assert property (p_ignore) else $error("ignored fault stopped output");

   property p_latch_hold;
      (state_reg == OCR_ST_LATCH) && output_on_cmd |=> (state_reg == OCR_ST_LATCH);
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("latched off left early");

   property p_retry_budget;
      (state_reg == OCR_ST_START) && (oc_restart_attempts != OCR_RETRY_FOREVER)
         |-> (attempts_reg <= oc_restart_attempts);
   endproperty
   a_retry_budget: assert property (p_retry_budget) else $error("restart budget exceeded");

   property p_delay_len;
      (state_reg == OCR_ST_DELAY) && oc_fault_detect && output_on_cmd && dly_done
         |=> !power_stage_en && (dly_cnt_reg == 3'h0);
   endproperty
   a_delay_len: assert property (p_delay_len) else $error("delayed shutdown missed");

   property p_hw_range;
      (warn_threshold_amps[0] >= OCR_HW_AMPS_MIN) && (warn_threshold_amps[0] <= OCR_HW_AMPS_MAX)
         && !warn_threshold_amps[0][0];
   endproperty
   a_hw_range: assert property (p_hw_range) else $error("threshold off grid");

   property p_invalid;
      invalid_event |=> stat_cml_invalid && host_alert && $stable(warn_words);
   endproperty
   a_invalid: assert property (p_invalid) else $error("bad write not rejected");

   property p_warn;
      |warn_hit |=> stat_byte_none_above && stat_word_iout &&
         ((stat_iout_warn & $past(warn_hit)) == $past(warn_hit));
   endproperty
   a_warn: assert property (p_warn) else $error("warning status not set");

   property p_attempt_clear;
      (state_reg == OCR_ST_START) && startup_done && !oc_fault_detect && output_on_cmd
         |=> (attempts_reg == 3'h0) && (state_reg == OCR_ST_RUN);
   endproperty
   a_attempt_clear: assert property (p_attempt_clear) else $error("attempts not cleared");

endmodule

`default_nettype wire

// ### testbench/ocr_host_model.sv
// host side model of the command port
`timescale 1ns/100ps
`default_nettype none

module ocr_host_model
   import ocr_pkg::*;
(
   input wire logic core_clk,
   output logic cmd_wr,
   output logic cmd_rd,
   output logic [7:0] cmd_code,
   output logic [15:0] cmd_wdata,
   output logic [7:0] phase_sel,
   input wire logic [15:0] cmd_rdata,
   input wire logic cmd_rd_valid
);
   // idle port at time zero
   initial
   begin
      cmd_wr = 1'b0;
      cmd_rd = 1'b0;
      cmd_code = 8'h00;
      cmd_wdata = 16'h0000;
      phase_sel = 8'h00;
   end
   // one write, strobe up for one edge, data scrambled after
   task automatic wr(input logic [7:0] code, input logic [7:0] ph, input logic [15:0] data);
      @(posedge core_clk);
      #1;
      cmd_code = code;
      phase_sel = ph;
      cmd_wdata = data;
      cmd_wr = 1'b1;
      @(posedge core_clk);
      #1;
      cmd_wr = 1'b0;
      cmd_wdata = ~data;
   endtask
   // one read, answer taken the cycle after the strobe
   task automatic rd(input logic [7:0] code, input logic [7:0] ph, output logic [15:0] d,
                     output logic v);
      @(posedge core_clk);
      #1;
      cmd_code = code;
      phase_sel = ph;
      cmd_rd = 1'b1;
      @(posedge core_clk);
      #1;
      cmd_rd = 1'b0;
      d = cmd_rdata;
      v = cmd_rd_valid;
   endtask
endmodule
`default_nettype wire

// ### testbench/ocr_fault_warn_tb_top.sv
// testbench for the overcurrent fault and warning block
`timescale 1ns/100ps
`default_nettype none

module ocr_fault_warn_tb_top;
   import ocr_pkg::*;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic cmd_wr, cmd_rd, cmd_rd_valid;
   logic [7:0] cmd_code, phase_sel;
   logic [15:0] cmd_wdata, cmd_rdata;
   logic output_on_cmd = 1'b0;
   logic startup_done = 1'b0;
   logic oc_fault_detect = 1'b0;
   logic [15:0] rise_time_us = 16'h0002;
   logic [OCR_NUM_PHASES-1:0][11:0] cur = '0;
   logic clear_faults = 1'b0;
   logic nvm_store = 1'b0;
   logic nvm_restore = 1'b0;
   logic power_stage_en, s_oc, s_none, s_word, s_fault, s_cml, host_alert;
   logic [OCR_NUM_PHASES-1:0][5:0] amps;
   logic [OCR_NUM_PHASES-1:0] s_warn;
   int n_mismatch = 0;
   int samples_checked = 0;
   int t, u;
   logic [2:0] dly [3] = '{3'h0, 3'h2, 3'h5};
   int tk [3] = '{1, 3, 7};
   int mul [3] = '{1, 2, 5};

   // free running clock
   always #5 core_clk = ~core_clk;

   ocr_host_model ocr_host_model_inst (.core_clk(core_clk), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
      .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .phase_sel(phase_sel),
      .cmd_rdata(cmd_rdata), .cmd_rd_valid(cmd_rd_valid));

   ocr_fault_warn ocr_fault_warn_inst (.core_clk(core_clk), .rst(rst), .cmd_wr(cmd_wr),
      .cmd_rd(cmd_rd), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .phase_sel(phase_sel),
      .cmd_rdata(cmd_rdata), .cmd_rd_valid(cmd_rd_valid), .output_on_cmd(output_on_cmd),
      .startup_done(startup_done), .oc_fault_detect(oc_fault_detect),
      .rise_time_us(rise_time_us), .phase_current(cur), .clear_faults(clear_faults),
      .nvm_store(nvm_store), .nvm_restore(nvm_restore), .power_stage_en(power_stage_en),
      .warn_threshold_amps(amps), .stat_byte_iout_oc(s_oc), .stat_byte_none_above(s_none),
      .stat_word_iout(s_word), .stat_iout_fault(s_fault), .stat_iout_warn(s_warn),
      .stat_cml_invalid(s_cml), .host_alert(host_alert));

   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   // cycles while the power stage holds a level, capped
   task automatic measure(input logic lvl, input int lim, output int n);
      n = 0;
      while (power_stage_en === lvl && n < lim)
      begin
         tick(1);
         n++;
      end
   endtask
   task automatic rd_chk(input logic [7:0] code, input logic [7:0] ph, input logic [15:0] exp);
      logic [15:0] d;
      logic v;
      ocr_host_model_inst.rd(code, ph, d, v);
      check({15'h0000, v}, 16'h0001);
      check(d, exp);
   endtask
   task automatic amps_chk(input logic [7:0] ph, input logic [15:0] w, input logic [5:0] a0,
                           input logic [5:0] a1);
      ocr_host_model_inst.wr(OCR_CMD_WARN_THRESHOLD, ph, w);
      tick(3);
      check(16'(amps[0]), 16'(a0));
      check(16'(amps[1]), 16'(a1));
   endtask
   // switch on, finish start-up, then raise the fault
   task automatic start_fault(input logic [7:0] act);
      ocr_host_model_inst.wr(OCR_CMD_FAULT_ACTION, 8'h00, {8'h00, act});
      output_on_cmd = 1'b1;
      measure(1'b0, 20, t);
      check(16'(t < 20), 16'h0001);
      startup_done = 1'b1;
      tick(1);
      startup_done = 1'b0;
      oc_fault_detect = 1'b1;
   endtask
   task automatic pulse_clear;
      oc_fault_detect = 1'b0;
      output_on_cmd = 1'b0;
      clear_faults = 1'b1;
      tick(1);
      clear_faults = 1'b0;
      tick(3);
   endtask

   // main sequence
   initial
   begin
      tick(3);
      rst = 1'b0;
      tick(3);
      rd_chk(OCR_CMD_FAULT_ACTION, 8'h00, 16'h0080);
      rd_chk(OCR_CMD_WARN_THRESHOLD, 8'h00, 16'hF0A0);
      rd_chk(8'h4B, 8'h00, 16'h0000);
      amps_chk(8'h00, 16'hF0A4, 6'h2A, 6'h28);
      amps_chk(8'h00, 16'hF014, 6'h08, 6'h28);
      rd_chk(OCR_CMD_WARN_THRESHOLD, 8'h00, 16'hF014);
      amps_chk(8'h01, 16'hF0F8, 6'h08, 6'h3E);
      amps_chk(8'h00, 16'hF0FC, 6'h08, 6'h3E);
      check({14'h0000, s_cml, host_alert}, 16'h0003);
      rd_chk(OCR_CMD_WARN_THRESHOLD, 8'h00, 16'hF014);
      pulse_clear();
      check(16'(s_cml), 16'h0000);
      amps_chk(8'h05, 16'hF050, 6'h08, 6'h3E);
      check(16'(s_cml), 16'h0001);
      amps_chk(OCR_PHASE_ALL, 16'hF0A0, 6'h14, 6'h14);
      rd_chk(OCR_CMD_WARN_THRESHOLD, OCR_PHASE_ALL, 16'hF0A0);
      rd_chk(OCR_CMD_WARN_THRESHOLD, 8'h01, 16'hE8A0);
      amps_chk(8'h00, 16'hE293, 6'h2A, 6'h14);
      nvm_store = 1'b1;
      tick(1);
      nvm_store = 1'b0;
      ocr_host_model_inst.wr(OCR_CMD_WARN_THRESHOLD, 8'h00, 16'hF014);
      nvm_restore = 1'b1;
      tick(1);
      nvm_restore = 1'b0;
      tick(2);
      rd_chk(OCR_CMD_WARN_THRESHOLD, 8'h00, 16'hF0A5);
      pulse_clear();
      // phase 1 limit is 20 A, compare is strictly above
      cur[1] = 12'h140;
      tick(3);
      check(16'(s_warn), 16'h0000);
      cur[1] = 12'h141;
      tick(3);
      check({12'h000, s_warn, s_none, s_word}, 16'h000B);
      check(16'(host_alert), 16'h0001);
      cur[1] = 12'h000;
      pulse_clear();
      start_fault(8'h40);
      tick(300);
      check({14'h0000, power_stage_en, s_fault}, 16'h0003);
      pulse_clear();
      start_fault(8'hC0);
      tick(2);
      check({11'h000, power_stage_en, s_oc, s_word, s_fault, host_alert}, 16'h000F);
      measure(1'b0, 600, t);
      check(16'(t), 16'h0258);
      pulse_clear();
      // delayed shutdown and restart wait per delay code, retry budget of one
      for (int i = 0; i < 3; i++)
      begin
         start_fault(8'h88 | 8'(dly[i]));
         measure(1'b1, 2000, t);
         check(16'(t > (tk[i] - 1) * 200 && t <= tk[i] * 200 + 3), 16'h0001);
         measure(1'b0, 3000, u);
         check(16'(u >= mul[i] * 200 - 100 && u <= mul[i] * 200 + 5), 16'h0001);
         measure(1'b1, 2000, t);
         measure(1'b0, 1500, u);
         check(16'(u), 16'h05DC);
         pulse_clear();
      end
      start_fault(8'hF8);
      for (int i = 0; i < 8; i++)
      begin
         measure(1'b1, 20, t);
         measure(1'b0, 400, u);
         check(16'(u < 400), 16'h0001);
      end
      pulse_clear();
      start_fault(8'hC8);
      measure(1'b1, 20, t);
      measure(1'b0, 400, u);
      oc_fault_detect = 1'b0;
      startup_done = 1'b1;
      tick(1);
      startup_done = 1'b0;
      tick(3);
      oc_fault_detect = 1'b1;
      measure(1'b1, 20, t);
      measure(1'b0, 400, u);
      check(16'(u < 400), 16'h0001);
      measure(1'b1, 20, t);
      measure(1'b0, 600, u);
      check(16'(u), 16'h0258);
      pulse_clear();
      end_sim();
   end
endmodule
`default_nettype wire
